// ==== core/rwc_pkg.sv ====
// Constants, types and field layouts for the reset and wake clock start-up sequencer.
// Assumes a single 40 MHz system clock; oscillator edges arrive as synchronous pulses.
// Function
// (RULE1) Any reset forces clock select to primary, one start-up path for all resets.
// (RULE2) Reset restores control register defaults; no transition from alternate clock.
// (RULE3) Crystal primary holds CPU in first phase until 1024 primary clocks counted.
// (RULE4) Execution and peripheral clocking suspended during oscillator start-up.
// (RULE5) Two-speed start-up runs from internal RC until start-up timer expires. Code runs the core with the source left on primary.
// (RULE6) RC, external or internal primary: no count, CPU start-up delay holds instead.
// (RULE7) After reset the CPU start-up timer runs; device held until it completes.
// (RULE8) Crystal start-up count runs in parallel with the CPU start-up timer.
// (RULE9) After both timers expire, wait one more clock before executing.
// (RULE10) Select 10: switch to internal RC after 8 clocks; done, secondary clear; stable set.
// (RULE11) Select 01 with secondary enabled: switch after 8 secondary clocks; running set.
// (RULE12) Select 00 with RC or external primary: switch after 8 primary clocks.
// (RULE13) Select 00 crystal: 1024 then 8 primary clocks; execution continues meanwhile. Code runs during the 1024, stops it for the 8 switch clocks.
// (RULE14) Fast internal oscillator: frequency stable flag set 4 ms after change.
// (RULE15) Any enabled interrupt wakes the device from sleep.
// (RULE16) Sleep leaves clock select unchanged; wake uses the selected source.
// (RULE17) Wake on 00: wait CPU timer and crystal count unless two-speed enabled.
// (RULE18) Wake on 01 or 10: wait only CPU start-up timer.
// (RULE19) Select to crystal primary before sleep: keep secondary, resume after count.
// (RULE20) Start-up done reads 1 only after count done and primary source in use.
// (RULE21) CPU start-up delay counts reference cycles, length a parameter.
package rwc_pkg;
   localparam logic [1:0] SEL_PRIMARY = 2'h0;
   localparam logic [1:0] SEL_SECONDARY = 2'h1;
   localparam logic [1:0] SEL_INTERNAL = 2'h2;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_TWO_SPEED_BIT = 2;
   localparam int CTRL_SEC_EN_BIT = 3;
   localparam int CTRL_FAST_BIT = 4;
   localparam int CTRL_WAKE_MASK_LSB = 8;
   // Avalon word addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_PRIMARY = 4'h2;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_STABLE_BIT = 1;
   localparam int STAT_SEC_RUN_BIT = 2;
   localparam int STAT_RUN_BIT = 3;
   localparam int STAT_SLEEP_BIT = 4;
   localparam int STAT_SRC_LSB = 5;
   localparam int OST_CLOCKS = 1024;
   localparam int SWITCH_CLOCKS = 8;
   localparam int CLK_HZ = 40_000_000;
   localparam int CPU_DELAY_NS = 10_000;
   localparam int CPU_DELAY_CYCLES = (CPU_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int STABLE_MS = 4;
   localparam int STABLE_CYCLES = STABLE_MS * (CLK_HZ / 1000);
   typedef enum logic [2:0] {
      RWC_PRI_LP, RWC_PRI_XT, RWC_PRI_HS, RWC_PRI_EC, RWC_PRI_RC, RWC_PRI_INTERNAL_RC_CLOCK
   } rwc_primary_t;
   typedef enum logic [1:0] {RWC_SRC_PRIMARY, RWC_SRC_SECONDARY, RWC_SRC_INTERNAL} rwc_source_t;
   typedef enum logic [2:0] {
      RWC_ST_STARTUP, RWC_ST_EXTRA, RWC_ST_RUN, RWC_ST_OST, RWC_ST_SWITCH, RWC_ST_SLEEP,
      RWC_ST_WAKE
   } rwc_state_t;
endpackage

// ==== core/rwc_startup.sv ====
// Reset and wake clock start-up sequencer with Avalon-MM register slave.
// Assumes oscillator edge inputs are one-cycle pulses synchronous to clk.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module rwc_startup #(
   parameter int STABLE_COUNT = rwc_pkg::STABLE_CYCLES,
   parameter int CPU_COUNT = rwc_pkg::CPU_DELAY_CYCLES
) (
   input wire logic clk, // System clock, 40 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic [3:0] avs_address, // Word address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall, low when answered
   input wire logic primary_edge, // Falling edge of primary oscillator
   input wire logic secondary_edge, // Falling edge of secondary oscillator
   input wire logic internal_edge, // Falling edge of internal RC clock
   input wire logic sleep_req, // Core executes sleep, pulse
   input wire logic [3:0] wake_irq, // Interrupt events, level
   output logic cpu_run, // Instruction execution enabled
   output logic periph_clk_en, // Peripheral clocking enabled
   output logic [1:0] sys_source, // Source feeding the system clock
   output logic startup_done_flag, // Oscillator start-up done
   output logic internal_freq_stable_flag, // Internal frequency stable
   output logic secondary_running_flag // Secondary oscillator is system clock
);
   // ==================================================
   // Functions
   function automatic logic is_crystal(input logic [2:0] p);
      return p == rwc_pkg::RWC_PRI_LP || p == rwc_pkg::RWC_PRI_XT ||
         p == rwc_pkg::RWC_PRI_HS;
   endfunction
   function automatic logic src_edge(input logic [1:0] s, input logic pe, input logic se,
         input logic ie);
      return (s == rwc_pkg::RWC_SRC_PRIMARY) ? pe :
         (s == rwc_pkg::RWC_SRC_SECONDARY) ? se : ie;
   endfunction

   // ==================================================
   // Registers
   logic [1:0] clock_select_field_reg;
   logic two_speed_reg;
   logic secondary_osc_enable_reg;
   logic fast_internal_reg;
   logic [3:0] wake_mask_reg;
   logic [2:0] primary_mode_reg;
   rwc_pkg::rwc_state_t state_reg;
   logic [1:0] target_reg;
   logic [10:0] ost_cnt_reg;
   logic ost_done_reg;
   logic [3:0] sw_cnt_reg;
   logic [31:0] cpu_cnt_reg;
   logic cpu_done_reg;
   logic [31:0] stable_cnt_reg;
   logic stable_run_reg;
   logic bus_ack_reg;
   logic [1:0] eff_sel;
   logic wake;
   logic crystal;
   logic want_change;

   // Secondary requires its enable; without it a 01 request falls back to primary
   assign eff_sel = (clock_select_field_reg == rwc_pkg::SEL_SECONDARY &&
      !secondary_osc_enable_reg) ? rwc_pkg::SEL_PRIMARY : clock_select_field_reg;
   assign wake = |(wake_irq & wake_mask_reg); // [RULE15]
   assign crystal = is_crystal(primary_mode_reg);
   assign want_change = eff_sel != sys_source;

   // ==================================================
   // Avalon slave: one wait cycle then answer
   always_ff @(posedge clk) begin
      if (rst) begin
         bus_ack_reg <= 1'b0;
      end else begin
         bus_ack_reg <= (avs_read || avs_write) && !bus_ack_reg;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !bus_ack_reg);
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !bus_ack_reg) begin
         unique case (avs_address)
            rwc_pkg::ADDR_CTRL: avs_readdata <= {20'h00000, wake_mask_reg, 3'h0,
               fast_internal_reg, secondary_osc_enable_reg, two_speed_reg,
               clock_select_field_reg};
            rwc_pkg::ADDR_STATUS: avs_readdata <= {25'h0000000, sys_source,
               state_reg == rwc_pkg::RWC_ST_SLEEP, cpu_run, secondary_running_flag,
               internal_freq_stable_flag, startup_done_flag};
            rwc_pkg::ADDR_PRIMARY: avs_readdata <= {29'h00000000, primary_mode_reg};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Control register: reset restores defaults, select back to primary
   always_ff @(posedge clk) begin
      if (rst) begin
         clock_select_field_reg <= rwc_pkg::SEL_RESET; // [RULE1] [RULE2]
         two_speed_reg <= rwc_pkg::CTRL_RESET[rwc_pkg::CTRL_TWO_SPEED_BIT];
         secondary_osc_enable_reg <= rwc_pkg::CTRL_RESET[rwc_pkg::CTRL_SEC_EN_BIT];
         fast_internal_reg <= rwc_pkg::CTRL_RESET[rwc_pkg::CTRL_FAST_BIT];
         wake_mask_reg <= 4'h0;
      end else if (avs_write && !bus_ack_reg && avs_address == rwc_pkg::ADDR_CTRL) begin
         // Sleep entry does not touch the select field
         clock_select_field_reg <= avs_writedata[rwc_pkg::CTRL_SEL_LSB +: 2]; // [RULE16]
         two_speed_reg <= avs_writedata[rwc_pkg::CTRL_TWO_SPEED_BIT];
         secondary_osc_enable_reg <= avs_writedata[rwc_pkg::CTRL_SEC_EN_BIT];
         fast_internal_reg <= avs_writedata[rwc_pkg::CTRL_FAST_BIT];
         wake_mask_reg <= avs_writedata[rwc_pkg::CTRL_WAKE_MASK_LSB +: 4];
      end
   end
   // Primary oscillator configuration, kept across reset like configuration bits
   always_ff @(posedge clk) begin
      if (avs_write && !bus_ack_reg && avs_address == rwc_pkg::ADDR_PRIMARY) begin
         primary_mode_reg <= avs_writedata[2:0];
      end else if (primary_mode_reg > rwc_pkg::RWC_PRI_INTERNAL_RC_CLOCK) begin
         primary_mode_reg <= rwc_pkg::RWC_PRI_EC;
      end
   end

   // ==================================================
   // CPU start-up delay counter
   always_ff @(posedge clk) begin
      if (rst || state_reg == rwc_pkg::RWC_ST_SLEEP) begin
         cpu_cnt_reg <= 32'h0000_0000; // [RULE7]
         cpu_done_reg <= 1'b0;
      end else if (!cpu_done_reg) begin
         cpu_cnt_reg <= cpu_cnt_reg + 32'h0000_0001; // [RULE21]
         cpu_done_reg <= cpu_cnt_reg == 32'(CPU_COUNT - 1); // [RULE6]
      end
   end

   // Oscillator start-up counter on primary edges, parallel with CPU timer
   always_ff @(posedge clk) begin
      // Restart on reset, in sleep and while running off the primary, so done stays set while running on it
      if (rst || state_reg == rwc_pkg::RWC_ST_SLEEP ||
            (state_reg == rwc_pkg::RWC_ST_RUN && sys_source != rwc_pkg::RWC_SRC_PRIMARY)) begin
         ost_cnt_reg <= 11'h000;
         ost_done_reg <= !crystal; // [RULE6]
      end else if (!ost_done_reg && primary_edge) begin
         ost_cnt_reg <= ost_cnt_reg + 11'h001; // [RULE8] [RULE3]
         ost_done_reg <= ost_cnt_reg == 11'(rwc_pkg::OST_CLOCKS - 1);
      end
   end

   // ==================================================
   // Sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= rwc_pkg::RWC_ST_STARTUP;
         target_reg <= rwc_pkg::RWC_SRC_PRIMARY;
         sw_cnt_reg <= 4'h0;
      end else begin
         unique case (state_reg)
            rwc_pkg::RWC_ST_STARTUP, rwc_pkg::RWC_ST_WAKE: begin
               if (cpu_done_reg && (ost_done_reg || sys_source != rwc_pkg::RWC_SRC_PRIMARY))
                  state_reg <= rwc_pkg::RWC_ST_EXTRA; // [RULE9] [RULE17] [RULE18]
            end
            rwc_pkg::RWC_ST_EXTRA: state_reg <= rwc_pkg::RWC_ST_RUN; // [RULE9]
            rwc_pkg::RWC_ST_RUN: begin
               if (sleep_req) begin
                  state_reg <= rwc_pkg::RWC_ST_SLEEP;
               end else if (want_change) begin
                  target_reg <= eff_sel;
                  sw_cnt_reg <= 4'h0;
                  state_reg <= (eff_sel == rwc_pkg::SEL_PRIMARY && crystal) ?
                     rwc_pkg::RWC_ST_OST : rwc_pkg::RWC_ST_SWITCH; // [RULE13]
               end
            end
            rwc_pkg::RWC_ST_OST: begin
               if (sleep_req) begin
                  state_reg <= rwc_pkg::RWC_ST_SLEEP; // [RULE19]
               end else if (ost_done_reg) begin
                  state_reg <= rwc_pkg::RWC_ST_SWITCH;
               end
            end
            rwc_pkg::RWC_ST_SWITCH: begin
               if (src_edge(target_reg, primary_edge, secondary_edge, internal_edge)) begin
                  sw_cnt_reg <= sw_cnt_reg + 4'h1; // [RULE10] [RULE11] [RULE12]
                  if (sw_cnt_reg == 4'(rwc_pkg::SWITCH_CLOCKS - 1))
                     state_reg <= rwc_pkg::RWC_ST_RUN;
               end
            end
            rwc_pkg::RWC_ST_SLEEP: if (wake) state_reg <= rwc_pkg::RWC_ST_WAKE; // [RULE15]
            default: state_reg <= rwc_pkg::RWC_ST_STARTUP;
         endcase
      end
   end

   // Source in use; wake jumps straight to the selected source
   always_ff @(posedge clk) begin
      if (rst) begin
         sys_source <= rwc_pkg::RWC_SRC_PRIMARY; // [RULE2]
      end else if (state_reg == rwc_pkg::RWC_ST_SWITCH &&
            src_edge(target_reg, primary_edge, secondary_edge, internal_edge) &&
            sw_cnt_reg == 4'(rwc_pkg::SWITCH_CLOCKS - 1)) begin
         sys_source <= target_reg;
      end else if (state_reg == rwc_pkg::RWC_ST_SLEEP && wake) begin
         sys_source <= eff_sel; // [RULE16] [RULE19]
      end
   end

   // Execution gate: two-speed lets the core run during crystal start-up once the CPU delay is done, source left on primary
   always_ff @(posedge clk) begin
      if (rst) begin
         cpu_run <= 1'b0;
         periph_clk_en <= 1'b0;
      end else begin
         cpu_run <= state_reg == rwc_pkg::RWC_ST_RUN || state_reg == rwc_pkg::RWC_ST_OST ||
            (state_reg inside {rwc_pkg::RWC_ST_STARTUP, rwc_pkg::RWC_ST_WAKE} &&
            two_speed_reg && crystal && cpu_done_reg &&
            sys_source == rwc_pkg::RWC_SRC_PRIMARY); // [RULE4] [RULE5] [RULE13]
         periph_clk_en <= state_reg != rwc_pkg::RWC_ST_SLEEP &&
            state_reg != rwc_pkg::RWC_ST_SWITCH &&
            (state_reg == rwc_pkg::RWC_ST_RUN || state_reg == rwc_pkg::RWC_ST_OST ||
            (two_speed_reg && crystal && cpu_done_reg)); // [RULE4]
      end
   end

   // ==================================================
   // Status flags
   always_ff @(posedge clk) begin
      if (rst) begin
         startup_done_flag <= 1'b0;
         secondary_running_flag <= 1'b0;
      end else begin
         startup_done_flag <= sys_source == rwc_pkg::RWC_SRC_PRIMARY && ost_done_reg &&
            state_reg != rwc_pkg::RWC_ST_SWITCH; // [RULE20] [RULE10] [RULE11] [RULE12]
         // Drops no later than the source leaves the secondary, never lags behind it
         secondary_running_flag <= sys_source == rwc_pkg::RWC_SRC_SECONDARY &&
            state_reg != rwc_pkg::RWC_ST_SWITCH &&
            !(state_reg == rwc_pkg::RWC_ST_SLEEP && wake); // [RULE11]
      end
   end
   always_ff @(posedge clk) begin
      if (rst || sys_source != rwc_pkg::RWC_SRC_INTERNAL) begin
         stable_cnt_reg <= 32'h0000_0000;
         stable_run_reg <= 1'b0;
         internal_freq_stable_flag <= 1'b0;
      end else if (!fast_internal_reg) begin
         internal_freq_stable_flag <= 1'b1; // [RULE10]
      end else if (!internal_freq_stable_flag) begin
         stable_cnt_reg <= stable_cnt_reg + 32'h0000_0001; // [RULE14]
         stable_run_reg <= 1'b1;
         internal_freq_stable_flag <= stable_cnt_reg == 32'(STABLE_COUNT - 1);
      end
   end
endmodule

// ==== tb/rwc_osc_model.sv ====
// Free-running oscillator edge source for the clock start-up sequencer.
// Assumes edges are one-cycle pulses synchronous to clk; slow stretches the primary period.
`timescale 1ns/10ps
module rwc_osc_model (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic slow, // Primary period 8 instead of 2
   output logic primary_edge, // Primary falling edge pulse
   output logic secondary_edge, // Secondary falling edge pulse
   output logic internal_edge // Internal RC falling edge pulse
);
   logic [7:0] cnt_reg;
   always_ff @(posedge clk) begin
      if (rst) cnt_reg <= 8'h00;
      else cnt_reg <= cnt_reg + 8'h01;
   end
   assign primary_edge = slow ? (cnt_reg[2:0] == 3'h0) : (cnt_reg[0] == 1'b0);
   assign secondary_edge = (cnt_reg[2:0] == 3'h3);
   assign internal_edge = (cnt_reg[1:0] == 2'h1);
endmodule

// ==== tb/rwc_startup_properties.sv ====
// Concurrent checks on the start-up sequencer ports.
// Assumes registered outputs and the one-cycle waitrequest answer of the slave.
`timescale 1ns/10ps
module rwc_startup_chk #(
   parameter int CPU_COUNT = 5
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic avs_waitrequest, // Stall
   input wire logic cpu_run, // Execution enabled
   input wire logic periph_clk_en, // Peripheral clocks
   input wire logic [1:0] sys_source, // System clock source
   input wire logic startup_done_flag, // Start-up done
   input wire logic internal_freq_stable_flag, // Internal stable
   input wire logic secondary_running_flag // Secondary in use
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic [15:0] since_rst;
   always_ff @(posedge clk) begin
      if (rst) since_rst <= 16'h0000;
      else if (since_rst != 16'hFFFF) since_rst <= since_rst + 16'h0001;
   end
   reset_state_a: assert property ($fell(rst) |->
      sys_source == 2'h0 && !cpu_run && !startup_done_flag && !secondary_running_flag)
      else $error("state not cleared");
   cpu_delay_a: assert property ($rose(cpu_run) |-> since_rst > CPU_COUNT)
      else $error("execution started early");
   run_periph_a: assert property (cpu_run |-> periph_clk_en)
      else $error("running without peripheral clocks");
   done_primary_a: assert property (startup_done_flag |-> sys_source == 2'h0)
      else $error("done flag off primary");
   sec_source_a: assert property (secondary_running_flag |-> sys_source == 2'h1)
      else $error("secondary flag without secondary source");
   flags_excl_a: assert property (!(startup_done_flag && secondary_running_flag))
      else $error("done and secondary flags both set");
   stable_int_a: assert property ($rose(internal_freq_stable_flag) |->
      sys_source == 2'h2) else $error("stable flag off internal source");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low twice");
   answer_time_a: assert property ((avs_read || avs_write) && avs_waitrequest |->
      ##[1:2] !avs_waitrequest) else $error("bus answer late");
   cover property (sys_source == 2'h1 ##1 sys_source == 2'h0);
   cover property ($rose(internal_freq_stable_flag));
   cover property ($rose(cpu_run));
endmodule
bind rwc_startup rwc_startup_chk #(.CPU_COUNT(CPU_COUNT)) chk_u (.clk(clk), .rst(rst),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .cpu_run(cpu_run), .periph_clk_en(periph_clk_en), .sys_source(sys_source),
   .startup_done_flag(startup_done_flag), .internal_freq_stable_flag(internal_freq_stable_flag),
   .secondary_running_flag(secondary_running_flag));

// ==== tb/reset_and_wake_clock_startup_bench.sv ====
// Self-checking bench for the start-up sequencer over its Avalon-MM registers.
// Assumes the oscillator model and shortened CPU and stable counts.
`timescale 1ns/10ps
module reset_and_wake_clock_startup_bench;
   localparam int CPU_N = 5;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, pe, se, ie, cpu_run, periph_clk_en, done_f, stable_f, sec_f;
   logic sleep_req = 1'b0;
   logic slow = 1'b0;
   logic [3:0] wake_irq = 4'h0;
   logic [1:0] sys_source;
   int n_fail = 0;
   int compares = 0;
   int n;
   always #12.5 clk = ~clk;
   rwc_osc_model osc_u (.clk(clk), .rst(rst), .slow(slow), .primary_edge(pe),
      .secondary_edge(se), .internal_edge(ie));
   rwc_startup #(.STABLE_COUNT(20), .CPU_COUNT(CPU_N)) dut_u (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .primary_edge(pe), .secondary_edge(se),
      .internal_edge(ie), .sleep_req(sleep_req), .wake_irq(wake_irq), .cpu_run(cpu_run),
      .periph_clk_en(periph_clk_en), .sys_source(sys_source), .startup_done_flag(done_f),
      .internal_freq_stable_flag(stable_f), .secondary_running_flag(sec_f));
   // ====================
   // Tasks
   task automatic give_verdict;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 100);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 100) begin
         chk(32'h1, 32'h0, "bus timeout");
         give_verdict();
      end
   endtask
   // Sel 0 waits for cpu_run, sel 1 for sys_source; n counts the edges
   task automatic waitv(input logic sel, input logic [1:0] v, output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while ((sel ? sys_source : {1'b0, cpu_run}) !== v && c < 20000);
      if (c >= 20000) begin
         chk(32'h1, 32'h0, "wait timeout");
         give_verdict();
      end
   endtask
   task automatic do_reset;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic sleep_wake(input logic [3:0] irq, output int c);
      @(posedge clk);
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
      wake_irq <= 4'h2;
      repeat (20) @(posedge clk);
      chk({31'h0, cpu_run}, 32'h0, "masked irq woke");
      wake_irq <= irq;
      waitv(0, 2'h1, c);
      wake_irq <= 4'h0;
   endtask
   // ====================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b1, 4'h2, 32'h3, q);
      do_reset();
      waitv(0, 2'h1, n);
      chk(32'(n > CPU_N && n < CPU_N + 8), 32'h1, "ec start delay");
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h0, "ctrl after reset");
      bus(1'b0, 4'h1, 32'h0, q);
      chk(q & 32'h7, 32'h1, "status ec");
      bus(1'b0, 4'h7, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
      bus(1'b1, 4'h0, 32'h12, q);
      waitv(1, 2'h2, n);
      chk(32'(n >= 28 && n < 45), 32'h1, "internal switch");
      repeat (25) @(posedge clk);
      chk({29'h0, sec_f, stable_f, done_f}, 32'h2, "internal flags");
      bus(1'b1, 4'h0, 32'h9, q);
      waitv(1, 2'h1, n);
      chk(32'(n >= 56 && n < 75), 32'h1, "secondary switch");
      repeat (2) @(posedge clk);
      chk({30'h0, sec_f, done_f}, 32'h2, "secondary flags");
      bus(1'b1, 4'h0, 32'h8, q);
      waitv(1, 2'h0, n);
      chk(32'(n >= 14 && n < 26), 32'h1, "ec return");
      repeat (2) @(posedge clk);
      chk({30'h0, sec_f, done_f}, 32'h1, "ec return flags");
      bus(1'b1, 4'h2, 32'h1, q);
      bus(1'b1, 4'h0, 32'h9, q);
      waitv(1, 2'h1, n);
      bus(1'b1, 4'h0, 32'h8, q);
      repeat (1000) @(posedge clk);
      chk({29'h0, cpu_run, sys_source}, 32'h5, "run on secondary during count");
      waitv(1, 2'h0, n);
      chk(32'(n + 1000 >= 2062), 32'h1, "crystal return length");
      repeat (2) @(posedge clk);
      chk({31'h0, done_f}, 32'h1, "crystal done");
      bus(1'b1, 4'h0, 32'h10A, q);
      waitv(1, 2'h2, n);
      sleep_wake(4'h1, n);
      chk(32'(n < CPU_N + 8), 32'h1, "wake on internal");
      chk({30'h0, sys_source}, 32'h2, "wake source");
      bus(1'b0, 4'h0, 32'h0, q);
      chk(q, 32'h10A, "ctrl kept over sleep");
      slow <= 1'b1;
      do_reset();
      waitv(0, 2'h1, n);
      chk(32'(n >= 8184), 32'h1, "crystal reset count");
      bus(1'b1, 4'h0, 32'h100, q);
      sleep_wake(4'h1, n);
      chk(32'(n >= 8184), 32'h1, "crystal wake count");
      bus(1'b1, 4'h0, 32'h104, q);
      sleep_wake(4'h1, n);
      chk(32'(n < CPU_N + 8), 32'h1, "two-speed early run");
      chk({29'h0, done_f, sys_source}, 32'h0, "two-speed count pending");
      give_verdict();
   end
endmodule
